/* rtl/ufb_window.v */
// Host access window onto the transmit and receive FIFOs of eight channels.
`timescale 1ns/1ps
`include "ufb_consts.vh"
module ufb_window #(
  parameter NCH = 8
) (
  // Clock, reset and enable
  input  wire                  core_clk,
  input  wire                  rstn,
  input  wire                  ce,
  // Host request
  input  wire                  req_valid,
  output reg                   req_ready,
  input  wire                  req_write,
  input  wire [`UFB_ADDR_W-1:0] req_addr,
  input  wire [3:0]            req_be,
  input  wire [31:0]           req_wdata,
  // Host response
  output reg                   rsp_valid,
  output reg                   rsp_err,
  output reg  [31:0]           rsp_rdata,
  // Channel transmit FIFOs
  input  wire [NCH-1:0]        tx_ready,
  output reg  [NCH-1:0]        tx_push,
  output reg  [7:0]            tx_data,
  // Channel receive FIFOs
  input  wire [NCH-1:0]        rx_valid,
  input  wire [NCH*8-1:0]      rx_data,
  input  wire [NCH*8-1:0]      rx_status,
  output reg  [NCH-1:0]        rx_pop
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam S_IDLE   = 2'h0;
  localparam S_WAITTX = 2'h1;
  localparam S_TAKE   = 2'h2;
  localparam S_GAP    = 2'h3;

  reg  [1:0]             state_reg, state_next;
  reg  [1:0]             lane_reg, lane_next;
  reg  [`UFB_CH_W-1:0]   rd_ch_reg, rd_ch_next;
  reg  [3:0]             rd_be_reg, rd_be_next;
  reg                    rd_stat_reg, rd_stat_next;
  reg  [31:0]            buf_reg, buf_next;
  reg                    req_ready_next;
  reg                    rsp_valid_next;
  reg                    rsp_err_next;
  reg  [31:0]            rsp_rdata_next;
  reg  [NCH-1:0]         rx_pop_next;
  reg                    lane_en;
  reg                    last_lane;

  reg  [1:0]             d_lane_reg, d_lane_next;
  reg                    d_gap_reg, d_gap_next;
  reg  [NCH-1:0]         tx_push_next;
  reg  [7:0]             tx_data_next;
  reg                    fo_ready;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire [`UFB_CH_W-1:0]   a_ch    = req_addr[`UFB_CH_LSB +: `UFB_CH_W];
  wire [`UFB_RGN_W-1:0]  a_rgn   = req_addr[`UFB_RGN_LSB +: `UFB_RGN_W];
  wire [`UFB_OFS_W-1:0]  a_ofs   = req_addr[`UFB_OFS_W-1:0];
  // Every offset of the plain window maps to the same FIFO, so a burst may walk it.
  wire                   is_plain = (a_rgn == `UFB_RGN_PLAIN);
  wire                   is_stat  = a_rgn[`UFB_RGN_STAT_BIT];
  wire                   is_hold  = (a_rgn == `UFB_RGN_HOLD) && (a_ofs == `UFB_HOLD_OFS);
  wire                   hold_ok  = is_hold && (req_be == `UFB_BE_SINGLE);
  wire                   wr_ok    = is_plain || hold_ok;
  wire                   rd_ok    = is_plain || hold_ok || is_stat;
  wire                   accept   = req_valid & req_ready;

  // --------------------------------------------------------------------------
  // Write buffer
  // --------------------------------------------------------------------------
  wire                   fi_valid = accept & req_write & wr_ok;
  wire                   fi_ready;
  wire                   fo_valid;
  wire [`UFB_WORD_W-1:0] fo_word;
  wire [3:0]             fo_be   = fo_word[`UFB_WBE_LSB +: 4];
  wire [`UFB_CH_W-1:0]   fo_ch   = fo_word[`UFB_WCH_LSB +: `UFB_CH_W];
  wire [NCH-1:0]         fo_hot  = {{(NCH-1){1'b0}}, 1'b1} << fo_ch;
  wire [NCH-1:0]         rd_hot  = {{(NCH-1){1'b0}}, 1'b1} << rd_ch_reg;
  // Reads wait for queued writes so a loopback test sees bytes in bus order.
  wire                   tx_busy = fo_valid | d_gap_reg;

  ufb_fifo #(
    .WIDTH (`UFB_WORD_W),
    .DEPTH (4),
    .AW    (2)
  ) u_wbuf (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (fi_valid),
    .in_ready  (fi_ready),
    .in_data   ({req_be, a_ch, req_wdata}),
    .out_valid (fo_valid),
    .out_ready (fo_ready),
    .out_data  (fo_word)
  );

  // --------------------------------------------------------------------------
  // Transmit drain, one byte lane at a time
  // --------------------------------------------------------------------------
  // The gap cycle lets the channel's ready reflect the byte just pushed.
  always @* begin
    d_lane_next  = d_lane_reg;
    d_gap_next   = 1'b0;
    tx_push_next = {NCH{1'b0}};
    tx_data_next = tx_data;
    fo_ready     = 1'b0;
    if (!d_gap_reg && fo_valid) begin
      if (!fo_be[d_lane_reg] || tx_ready[fo_ch]) begin
        if (fo_be[d_lane_reg]) begin
          tx_push_next = fo_hot;
          tx_data_next = fo_word[{d_lane_reg, 3'b000} +: 8];
          d_gap_next   = 1'b1;
        end
        d_lane_next = d_lane_reg + 2'd1;
        fo_ready    = (d_lane_reg == 2'd3);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Request and receive sequencer
  // --------------------------------------------------------------------------
  always @* begin
    state_next     = state_reg;
    lane_next      = lane_reg;
    rd_ch_next     = rd_ch_reg;
    rd_be_next     = rd_be_reg;
    rd_stat_next   = rd_stat_reg;
    buf_next       = buf_reg;
    req_ready_next = req_ready;
    rsp_valid_next = 1'b0;
    rsp_err_next   = 1'b0;
    rsp_rdata_next = rsp_rdata;
    rx_pop_next    = {NCH{1'b0}};
    lane_en        = rd_stat_reg ? (rd_be_reg[lane_reg] | rd_be_reg[lane_reg | 2'd1])
                                 : rd_be_reg[lane_reg];
    last_lane      = rd_stat_reg ? (lane_reg == 2'd2) : (lane_reg == 2'd3);
    case (state_reg)
      S_IDLE: begin
        req_ready_next = fi_ready;
        if (accept) begin
          req_ready_next = 1'b0;
          if (req_write || !rd_ok) begin
            rsp_valid_next = 1'b1;
            rsp_err_next   = req_write ? !wr_ok : 1'b1;
            rsp_rdata_next = `UFB_RST_DATA;
          end else begin
            state_next   = S_WAITTX;
            rd_ch_next   = a_ch;
            rd_be_next   = req_be;
            rd_stat_next = is_stat;
            lane_next    = 2'd0;
            buf_next     = `UFB_RST_DATA;
          end
        end
      end
      S_WAITTX: begin
        if (!tx_busy) begin
          state_next = S_TAKE;
        end
      end
      S_TAKE: begin
        if (lane_en && rx_valid[rd_ch_reg]) begin
          rx_pop_next = rd_hot;
          state_next  = S_GAP;
          if (rd_stat_reg) begin
            buf_next[{lane_reg, 3'b000} +: 8]           = rx_status[{rd_ch_reg, 3'b000} +: 8];
            buf_next[({lane_reg, 3'b000} + 5'd8) +: 8]  = rx_data[{rd_ch_reg, 3'b000} +: 8];
          end else begin
            buf_next[{lane_reg, 3'b000} +: 8] = rx_data[{rd_ch_reg, 3'b000} +: 8];
          end
        end else if (last_lane) begin
          state_next     = S_IDLE;
          rsp_valid_next = 1'b1;
          rsp_rdata_next = buf_reg;
        end else begin
          lane_next = lane_reg + (rd_stat_reg ? 2'd2 : 2'd1);
        end
      end
      S_GAP: begin
        if (last_lane) begin
          state_next     = S_IDLE;
          rsp_valid_next = 1'b1;
          rsp_rdata_next = buf_reg;
        end else begin
          state_next = S_TAKE;
          lane_next  = lane_reg + (rd_stat_reg ? 2'd2 : 2'd1);
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= S_IDLE;
      lane_reg    <= 2'd0;
      rd_ch_reg   <= {`UFB_CH_W{1'b0}};
      rd_be_reg   <= 4'h0;
      rd_stat_reg <= 1'b0;
      buf_reg     <= `UFB_RST_DATA;
      req_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_err     <= 1'b0;
      rsp_rdata   <= `UFB_RST_DATA;
      rx_pop      <= {NCH{1'b0}};
      d_lane_reg  <= 2'd0;
      d_gap_reg   <= 1'b0;
      tx_push     <= {NCH{1'b0}};
      tx_data     <= `UFB_RST_BYTE;
    end else if (ce) begin
      state_reg   <= state_next;
      lane_reg    <= lane_next;
      rd_ch_reg   <= rd_ch_next;
      rd_be_reg   <= rd_be_next;
      rd_stat_reg <= rd_stat_next;
      buf_reg     <= buf_next;
      req_ready   <= req_ready_next;
      rsp_valid   <= rsp_valid_next;
      rsp_err     <= rsp_err_next;
      rsp_rdata   <= rsp_rdata_next;
      rx_pop      <= rx_pop_next;
      d_lane_reg  <= d_lane_next;
      d_gap_reg   <= d_gap_next;
      tx_push     <= tx_push_next;
      tx_data     <= tx_data_next;
    end
  end

endmodule // ufb_window

/* inc/ufb_consts.vh */
// Address map and field constants of the FIFO burst access window.
`ifndef UFB_CONSTS_VH
`define UFB_CONSTS_VH

// ----------------------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------------------
`define UFB_ADDR_W      13
`define UFB_CH_LSB      10
`define UFB_CH_W        3
`define UFB_RGN_LSB     8
`define UFB_RGN_W       2
`define UFB_OFS_W       8
`define UFB_RGN_HOLD    2'h0
`define UFB_RGN_PLAIN   2'h1
`define UFB_RGN_STAT_BIT 1
`define UFB_HOLD_OFS    8'h00
`define UFB_BE_SINGLE   4'h1

// ----------------------------------------------------------------------------
// Transmit word layout in the write buffer
// ----------------------------------------------------------------------------
`define UFB_WORD_W      39
`define UFB_WBE_LSB     35
`define UFB_WCH_LSB     32

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UFB_RST_DATA    32'h0000_0000
`define UFB_RST_BYTE    8'h00

`endif

/* rtl/ufb_fifo.v */
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ufb_fifo #(
  parameter WIDTH = 39,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock, reset and enable
  input  wire             core_clk,
  input  wire             rstn,
  input  wire             ce,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;

  wire            do_push;
  wire            do_pop;
  integer         i;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {WIDTH{1'b0}};
      end
    end else if (ce) begin
      if (do_push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // ufb_fifo

/* test/ufb_window_sva.sv */
// Port assertions for the FIFO burst access window.
`timescale 1ns/1ps
`include "ufb_consts.vh"
module ufb_window_chk #(
  parameter NCH = 8
) (
  input wire                   core_clk,
  input wire                   rstn,
  input wire                   ce,
  input wire                   req_valid,
  input wire                   req_ready,
  input wire                   req_write,
  input wire [`UFB_ADDR_W-1:0] req_addr,
  input wire [3:0]             req_be,
  input wire                   rsp_valid,
  input wire                   rsp_err,
  input wire [NCH-1:0]         rx_valid,
  input wire [NCH-1:0]         rx_pop,
  input wire [NCH-1:0]         tx_push
);
  wire take = req_valid && req_ready;
  wire hold = req_addr[9:8] == `UFB_RGN_HOLD;
  wire bad  = (hold && (req_addr[7:0] != `UFB_HOLD_OFS || req_be != `UFB_BE_SINGLE))
              || (req_write && req_addr[9]);
  // A frozen clock enable stalls the whole block, so the checks pause with it.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn || !ce);
  a_bad_access_err: assert property (take && bad |=> rsp_valid && rsp_err)
    else $error("illegal access not refused next cycle");
  a_write_ack_ok: assert property (take && req_write && !bad |=> rsp_valid && !rsp_err)
    else $error("legal write not acknowledged");
  a_read_answer_time: assert property (take && !req_write && !bad
    |=> !rsp_valid [*3] ##[1:400] rsp_valid) else $error("read answer out of time");
  a_ready_drops: assert property (take |=> !req_ready) else $error("ready held after accept");
  a_rsp_one_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("response too long");
  a_push_one_byte: assert property (|tx_push |-> $onehot(tx_push) ##1 tx_push == 8'h00)
    else $error("push not a single one-hot pulse");
  a_pop_one_byte: assert property (|rx_pop |-> $onehot(rx_pop) ##1 rx_pop == 8'h00)
    else $error("pop not a single one-hot pulse");
  a_pop_when_filled: assert property (|rx_pop |-> ($past(rx_valid) & rx_pop) == rx_pop)
    else $error("pop from an empty receive fifo");
endmodule // ufb_window_chk

bind ufb_window ufb_window_chk #(.NCH(NCH)) chk (.core_clk(core_clk), .rstn(rstn), .ce(ce),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
  .req_be(req_be), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rx_valid(rx_valid),
  .rx_pop(rx_pop), .tx_push(tx_push));

/* test/ufb_chan_model.sv */
// Behavioural model of the eight channel FIFOs beside the access window.
`timescale 1ns/1ps
module ufb_chan_model (
  input  wire         core_clk,
  input  wire         stall,
  input  wire [7:0]   rx_pop,
  output logic [7:0]  tx_ready,
  output logic [7:0]  rx_valid,
  output logic [63:0] rx_data,
  output logic [63:0] rx_status
);
  // Each entry is {data, line_status_byte}.
  logic [15:0] rxq[8][$];
  initial begin
    tx_ready = 8'hff;
    rx_valid = 8'h00;
    rx_data = 64'h0;
    rx_status = 64'h0;
  end
  task automatic load(input int ch, input logic [15:0] e);
    rxq[ch].push_back(e);
  endtask
  // An empty fifo shows inverted stale bytes so nothing can pass by luck.
  always @(posedge core_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (rx_pop[i] && rxq[i].size() > 0) void'(rxq[i].pop_front());
      rx_valid[i] <= rxq[i].size() > 0;
      rx_data[i*8 +: 8] <= rxq[i].size() > 0 ? rxq[i][0][15:8] : ~rx_data[i*8 +: 8];
      rx_status[i*8 +: 8] <= rxq[i].size() > 0 ? rxq[i][0][7:0] : ~rx_status[i*8 +: 8];
    end
    tx_ready <= stall ? 8'($urandom) : 8'hff;
  end
endmodule // ufb_chan_model

/* test/tb_uart_fifo_burst_access_window.sv */
// Self-checking bench for the FIFO burst access window.
`timescale 1ns/1ps
module tb_uart_fifo_burst_access_window;
  logic        core_clk = 0;
  logic        rstn = 0;
  logic        ce = 1;
  logic        req_valid = 0;
  logic        req_write = 0;
  logic        stall = 0;
  logic [12:0] req_addr = 0;
  logic [3:0]  req_be = 0;
  logic [31:0] req_wdata = 0;
  wire         req_ready, rsp_valid, rsp_err;
  wire  [31:0] rsp_rdata;
  wire  [7:0]  tx_ready, tx_push, tx_data, rx_valid, rx_pop;
  wire  [63:0] rx_data, rx_status;
  logic [32:0] exp_rsp[$];
  logic [10:0] exp_tx[$];
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  always #2 core_clk = ~core_clk;
  ufb_window #(.NCH(8)) uut (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_be(req_be), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata), .tx_ready(tx_ready), .tx_push(tx_push), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_status(rx_status), .rx_pop(rx_pop));
  ufb_chan_model mdl (.core_clk(core_clk), .stall(stall), .rx_pop(rx_pop),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_status(rx_status));
  task automatic note(input string what, input logic [32:0] e, input logic [32:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_rsp(input logic [32:0] e, input logic [32:0] g);
    note("response", e, g);
  endtask
  task automatic cmp_tx(input logic [10:0] e, input logic [10:0] g);
    note("push", {22'h0, e}, {22'h0, g});
  endtask
  function automatic logic [2:0] enc(input logic [7:0] v);
    enc = 3'h0;
    for (int i = 0; i < 8; i++) if (v[i]) enc = i[2:0];
  endfunction
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Outputs are flops, so the old values read here were settled one edge ago.
  always @(posedge core_clk) begin
    cyc++;
    if (rsp_valid === 1'b1) cmp_rsp(exp_rsp.size() ? exp_rsp.pop_front() : 'x, {rsp_err, rsp_rdata});
    if (tx_push !== 8'h00) cmp_tx(exp_tx.size() ? exp_tx.pop_front() : 'x, {enc(tx_push), tx_data});
    // The run ends last in this process so nothing is left to run after it.
    if (cyc > 60000) begin
      error_cnt++;
      complete_run();
    end
  end
  // One host access; the expected result is noted before the request goes out.
  task automatic acc(input bit we, input int ch, input logic [9:0] ofs, input logic [3:0] be,
                     input logic [31:0] wd);
    logic [31:0] r;
    logic [15:0] q;
    int k;
    bit bad;
    r = 0;
    k = 0;
    bad = (ofs[9:8] == 2'h0 && (ofs[7:0] != 8'h00 || be != 4'h1)) || (we && ofs[9]);
    if (bad) exp_rsp.push_back({1'b1, 32'h0});
    else if (we) begin
      exp_rsp.push_back(33'h0);
      for (int l = 0; l < 4; l++) if (be[l]) exp_tx.push_back({ch[2:0], wd[l*8 +: 8]});
    end else begin
      // An earlier read pops its bytes after it is taken, so wait for its answer first.
      while (exp_rsp.size() != 0) @(posedge core_clk);
      for (int l = 0; l < 4; l++) begin
        if ((ofs[9] ? (l % 2 == 0 && (be[l] || be[l+1])) : be[l]) && k < mdl.rxq[ch].size()) begin
          q = mdl.rxq[ch][k];
          k++;
          if (ofs[9]) r[l*8 +: 16] = q;
          else r[l*8 +: 8] = q[15:8];
        end
      end
      exp_rsp.push_back({1'b0, r});
    end
    @(posedge core_clk);
    req_valid <= 1;
    req_write <= we;
    req_addr <= {ch[2:0], ofs};
    req_be <= be;
    req_wdata <= wd;
    do @(negedge core_clk); while (req_ready !== 1'b1);
    @(posedge core_clk);
    req_valid <= 0;
  endtask
  initial begin
    void'($urandom(92));
    repeat (6) @(posedge core_clk);
    rstn <= 1;
    repeat (2) @(posedge core_clk);
    for (int ch = 0; ch < 8; ch++) begin
      acc(1, ch, 10'h100 + 10'(ch * 4), 4'($urandom_range(15, 1)), $urandom);
      acc(1, ch, 10'h000, 4'h1, $urandom);
    end
    stall <= 1;
    repeat (64) acc(1, 3, 10'h1fc, 4'hf, $urandom);
    stall <= 0;
    acc(1, 2, 10'h004, 4'hf, $urandom);
    acc(0, 2, 10'h000, 4'h3, 32'h0);
    acc(1, 2, 10'h200, 4'hf, $urandom);
    for (int ch = 0; ch < 8; ch++) begin
      repeat (6) mdl.load(ch, 16'($urandom));
      acc(0, ch, 10'h1f0, 4'($urandom_range(15, 1)), 32'h0);
      acc(0, ch, 10'h3fc, 4'hf, 32'h0);
      acc(0, ch, 10'h000, 4'h1, 32'h0);
      acc(0, ch, 10'h200, 4'h3, 32'h0);
    end
    while (exp_rsp.size() || exp_tx.size()) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    complete_run();
  end
endmodule // tb_uart_fifo_burst_access_window
